// *** pkg/flash_poll_pkg.sv ***
package flash_poll_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int STROBE_NS = 70;
    localparam int RECOVER_NS = 20;
    localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_CYC =
        (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] STROBE_LOAD = 4'(STROBE_CYC - 1);
    localparam logic [3:0] RECOVER_LOAD = 4'(RECOVER_CYC - 1);

    // ----------------------------------------------------------------
    // Flash bus widths and status bit positions
    // ----------------------------------------------------------------
    localparam int ADDR_W = 18;
    localparam int DQ_W = 16;
    localparam int POLL_STATUS_BIT = 7;
    localparam int TOGGLE_ONE_BIT = 6;
    localparam int TIMEOUT_FAIL_BIT = 5;
    localparam int ERASE_WINDOW_BIT = 3;
    localparam int TOGGLE_TWO_BIT = 2;
    localparam logic [DQ_W-1:0] RESET_CMD = 16'h00F0;

    // ----------------------------------------------------------------
    // Software register map
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RDATA = 8'h10;
    localparam int CTL_DATA_POLL = 0;
    localparam int CTL_TOGGLE_POLL = 1;
    localparam int CTL_READ = 2;
    localparam int CTL_WRITE = 3;
    localparam int CTL_RESET = 4;
    localparam int CTL_ABORT = 5;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_PASS = 2;
    localparam int STAT_FAIL = 3;
    localparam int STAT_WINDOW = 4;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic ce_b;
        logic oe_b;
        logic we_b;
        logic [ADDR_W-1:0] addr;
        logic [DQ_W-1:0] dq;
        logic dq_oe;
    } flash_pins_s;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DQ_W-1:0] data;
    } cyc_req_s;

    localparam flash_pins_s PINS_IDLE = '{1'b1, 1'b1, 1'b1, '0, '0, 1'b0};

endpackage : flash_poll_pkg

// *** verilog/flash_bus_cycle.sv ***
`timescale 1ns/100ps
module flash_bus_cycle import flash_poll_pkg::*; (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Cycle request
    input wire cyc_req_s req_i,
    output logic done_o,
    output logic [DQ_W-1:0] rdata_o,
    // Flash pins
    input wire logic [DQ_W-1:0] dq_i,
    output flash_pins_s pins_o
);

    typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_RECOVER} cyc_e;

    typedef struct packed {
        cyc_e st;
        logic [3:0] cnt;
        logic is_wr;
        flash_pins_s pins;
        logic done;
        logic [DQ_W-1:0] rdata;
    } cyc_state_s;

    localparam cyc_state_s CYC_RST = '{C_IDLE, 4'h0, 1'b0, PINS_IDLE, 1'b0,
                                       16'h0000};

    cyc_state_s s;
    cyc_state_s next_s;

    // ----------------------------------------------------------------
    // One bus cycle: chip select frames every strobe
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        case (s.st)
            C_IDLE: begin
                if (req_i.rd || req_i.wr) begin
                    next_s.pins.ce_b = 1'b0;
                    next_s.pins.addr = req_i.addr;
                    next_s.pins.dq = req_i.data;
                    next_s.pins.dq_oe = req_i.wr;
                    next_s.is_wr = req_i.wr;
                    next_s.st = C_SETUP;
                end
            end
            C_SETUP: begin
                // Each read gets its own falling output enable
                if (s.is_wr) begin
                    next_s.pins.we_b = 1'b0;
                end else begin
                    next_s.pins.oe_b = 1'b0;
                end
                next_s.cnt = STROBE_LOAD;
                next_s.st = C_STROBE;
            end
            C_STROBE: begin
                if (s.cnt == 4'h0) begin
                    // Sample at the end so a late status flip has settled
                    if (!s.is_wr) begin
                        next_s.rdata = dq_i;
                    end
                    next_s.pins.oe_b = 1'b1;
                    next_s.pins.we_b = 1'b1;
                    next_s.cnt = RECOVER_LOAD;
                    next_s.st = C_RECOVER;
                end else begin
                    next_s.cnt = s.cnt - 4'h1;
                end
            end
            default: begin
                if (s.cnt == 4'h0) begin
                    next_s.pins.ce_b = 1'b1;
                    next_s.pins.dq_oe = 1'b0;
                    next_s.done = 1'b1;
                    next_s.st = C_IDLE;
                end else begin
                    next_s.cnt = s.cnt - 4'h1;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s <= CYC_RST;
        end else begin
            s <= next_s;
        end
    end

    assign pins_o = s.pins;
    assign done_o = s.done;
    assign rdata_o = s.rdata;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_strobe_width: assert property (
        $fell(pins_o.oe_b) |-> !pins_o.oe_b [*7] ##1 pins_o.oe_b)
        else $error("read strobe width wrong");
    a_ce_frames_read: assert property (
        !pins_o.oe_b || !pins_o.we_b |-> !pins_o.ce_b ##1 !pins_o.ce_b)
        else $error("strobe outside chip select");

endmodule : flash_bus_cycle

// *** verilog/flash_status_poller.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - Erase polling uses unprotected erasing sector address
// - Reread after poll match for full byte
// - Non-blank program locks; host sends reset
// - Check erase window around added erase commands
// - Two reads compared detect toggle completion
// - Toggling with fail bit: recheck, then reset
// - Resumed monitoring restarts from first step
module flash_status_poller import flash_poll_pkg::*; (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Software register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Flash pins
    output logic ce_b_o,
    output logic oe_b_o,
    output logic we_b_o,
    output logic [ADDR_W-1:0] addr_o,
    input wire logic [DQ_W-1:0] dq_i,
    output logic [DQ_W-1:0] dq_o,
    output logic dq_oe_o
);

    typedef enum logic [1:0] {P_IDLE, P_WAIT, P_DRAIN} phase_e;
    typedef enum logic [2:0] {A_DATA, A_TOGGLE, A_READ, A_WRITE, A_RESET} algo_e;

    typedef struct packed {
        phase_e phase;
        algo_e algo;
        logic [1:0] step;
        logic [7:0] first;
        logic [ADDR_W-1:0] addr;
        logic [DQ_W-1:0] wdata;
        logic [DQ_W-1:0] rdata;
        cyc_req_s req;
        logic busy;
        logic done;
        logic pass;
        logic fail;
        logic window;
        logic [31:0] reg_rdata;
    } poll_state_s;

    poll_state_s s;
    poll_state_s next_s;
    flash_pins_s pins;
    logic cyc_done;
    logic [DQ_W-1:0] cyc_rdata;
    logic [7:0] d;
    logic ctl_wr;

    assign d = cyc_rdata[7:0];
    assign ctl_wr = reg_wr_i && (reg_addr_i == REG_CTRL);

    // ----------------------------------------------------------------
    // Register port and polling sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.req.rd = 1'b0;
        next_s.req.wr = 1'b0;
        next_s.reg_rdata = 32'h0000_0000;
        // Completed bus cycle: drop it when draining, else evaluate the status byte
        if (cyc_done && s.phase == P_DRAIN) begin
            next_s.phase = P_IDLE;
            next_s.busy = 1'b0;
        end else if (cyc_done && s.phase == P_WAIT) begin
            next_s.rdata = cyc_rdata;
            next_s.window = d[ERASE_WINDOW_BIT];
            case (s.algo)
                A_DATA: begin
                    // Erase expects 1 on the poll bit, program the data
                    if (s.step == 2'd2) begin
                        next_s.pass = 1'b1;
                    end else if (d[POLL_STATUS_BIT] ==
                                 s.wdata[POLL_STATUS_BIT]) begin
                        // Low bits may lag the poll bit: read again
                        next_s.step = 2'd2;
                        next_s.req.rd = 1'b1;
                    end else if (s.step == 2'd1) begin
                        next_s.fail = 1'b1;
                    end else if (d[TIMEOUT_FAIL_BIT]) begin
                        next_s.step = 2'd1;
                        next_s.req.rd = 1'b1;
                    end else begin
                        next_s.req.rd = 1'b1;
                    end
                end
                A_TOGGLE: begin
                    next_s.first = d;
                    if (s.step == 2'd2) begin
                        next_s.pass = 1'b1;
                    end else if (s.step == 2'd0) begin
                        next_s.step = 2'd1;
                        next_s.req.rd = 1'b1;
                    end else if (d[TOGGLE_ONE_BIT] ==
                                 s.first[TOGGLE_ONE_BIT]) begin
                        // Stopped toggling: next read is array data
                        next_s.step = 2'd2;
                        next_s.req.rd = 1'b1;
                    end else if (s.step == 2'd3) begin
                        next_s.fail = 1'b1;
                    end else if (d[TIMEOUT_FAIL_BIT]) begin
                        next_s.step = 2'd3;
                        next_s.req.rd = 1'b1;
                    end else begin
                        next_s.req.rd = 1'b1;
                    end
                end
                default: begin
                    next_s.pass = (s.algo != A_RESET);
                end
            endcase
            if (next_s.fail && !s.fail) begin
                // Locked algorithm only leaves through reset
                next_s.algo = A_RESET;
                next_s.req.wr = 1'b1;
                next_s.req.data = RESET_CMD;
            end else if (!next_s.req.rd) begin
                next_s.phase = P_IDLE;
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
            end
        end
        // Software writes
        if (reg_wr_i) begin
            if (reg_addr_i == REG_ADDR) begin
                next_s.addr = reg_wdata_i[ADDR_W-1:0];
            end else if (reg_addr_i == REG_WDATA) begin
                next_s.wdata = reg_wdata_i[DQ_W-1:0];
            end else if (reg_addr_i == REG_CTRL) begin
                if (reg_wdata_i[CTL_ABORT]) begin
                    // A later start always begins at step zero
                    next_s.step = 2'd0;
                    next_s.req.rd = 1'b0;
                    next_s.req.wr = 1'b0;
                    // A cycle that ends in this very clock has nothing
                    // left to drain, so waiting for it would hang
                    if (s.phase == P_WAIT && !cyc_done) begin
                        next_s.phase = P_DRAIN;
                    end else if (s.phase == P_WAIT) begin
                        next_s.phase = P_IDLE;
                        next_s.busy = 1'b0;
                    end
                end else if (!s.busy &&
                             (|reg_wdata_i[CTL_RESET:CTL_DATA_POLL])) begin
                    next_s.busy = 1'b1;
                    next_s.done = 1'b0;
                    next_s.pass = 1'b0;
                    next_s.fail = 1'b0;
                    next_s.step = 2'd0;
                    next_s.phase = P_WAIT;
                    // Every poll read uses the software address
                    next_s.req.addr = s.addr;
                    next_s.req.data = s.wdata;
                    if (reg_wdata_i[CTL_DATA_POLL]) begin
                        next_s.algo = A_DATA;
                    end else if (reg_wdata_i[CTL_TOGGLE_POLL]) begin
                        next_s.algo = A_TOGGLE;
                    end else if (reg_wdata_i[CTL_READ]) begin
                        next_s.algo = A_READ;
                    end else if (reg_wdata_i[CTL_WRITE]) begin
                        next_s.algo = A_WRITE;
                    end else begin
                        next_s.algo = A_RESET;
                        next_s.req.data = RESET_CMD;
                    end
                    // Only the winning start bit chooses the cycle type
                    next_s.req.wr = (next_s.algo == A_WRITE)
                                    || (next_s.algo == A_RESET);
                    next_s.req.rd = !next_s.req.wr;
                end
            end
        end
        // Software reads, answered in the next cycle only
        if (reg_rd_i) begin
            if (reg_addr_i == REG_ADDR) begin
                next_s.reg_rdata[ADDR_W-1:0] = s.addr;
            end else if (reg_addr_i == REG_WDATA) begin
                next_s.reg_rdata[DQ_W-1:0] = s.wdata;
            end else if (reg_addr_i == REG_STATUS) begin
                next_s.reg_rdata[STAT_BUSY] = s.busy;
                next_s.reg_rdata[STAT_DONE] = s.done;
                next_s.reg_rdata[STAT_PASS] = s.pass;
                next_s.reg_rdata[STAT_FAIL] = s.fail;
                next_s.reg_rdata[STAT_WINDOW] = s.window;
            end else if (reg_addr_i == REG_RDATA) begin
                next_s.reg_rdata[DQ_W-1:0] = s.rdata;
            end
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Bus cycle engine drives the pins from its own flops
    flash_bus_cycle u_cycle (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .req_i(s.req),
        .done_o(cyc_done),
        .rdata_o(cyc_rdata),
        .dq_i(dq_i),
        .pins_o(pins)
    );

    assign ce_b_o = pins.ce_b;
    assign oe_b_o = pins.oe_b;
    assign we_b_o = pins.we_b;
    assign addr_o = pins.addr;
    assign dq_o = pins.dq;
    assign dq_oe_o = pins.dq_oe;
    assign reg_rdata_o = s.reg_rdata;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_poll_addr_fixed: assert property (
        s.busy && s.algo == A_DATA && !oe_b_o |-> addr_o == s.addr)
        else $error("poll read left the chosen address");
    a_pass_after_verify: assert property (
        $rose(s.pass) && s.algo == A_DATA |-> $past(s.step) == 2'd2)
        else $error("data poll passed without verify read");
    a_fail_sends_reset: assert property (
        $rose(s.fail) |-> ##[1:4] (!we_b_o && dq_o == RESET_CMD))
        else $error("no reset command after failure");
    a_toggle_second_read: assert property (
        s.algo == A_TOGGLE && s.phase == P_WAIT && cyc_done
        && s.step == 2'd0 && !ctl_wr |=> s.step == 2'd1 && s.req.rd)
        else $error("toggle check skipped second read");
    a_recheck_on_fail: assert property (
        s.algo == A_TOGGLE && s.phase == P_WAIT && cyc_done && !ctl_wr
        && s.step == 2'd1 && d[TIMEOUT_FAIL_BIT]
        && d[TOGGLE_ONE_BIT] != s.first[TOGGLE_ONE_BIT]
        |=> s.step == 2'd3 && !s.fail)
        else $error("fail bit seen without recheck");
    a_abort_restarts: assert property (
        ctl_wr && reg_wdata_i[CTL_ABORT] |=> s.step == 2'd0
        && s.phase != P_WAIT)
        else $error("abort did not restart sequence");
    a_window_capture: assert property (
        s.phase == P_WAIT && cyc_done |=>
        s.window == $past(cyc_rdata[ERASE_WINDOW_BIT]))
        else $error("erase window flag not captured");
    a_done_clears_busy: assert property (
        $rose(s.done) |-> !s.busy ##1 (!s.busy || $past(ctl_wr)))
        else $error("done while still busy");

    c_data_pass: cover property ($rose(s.pass) && s.algo == A_DATA);
    c_toggle_pass: cover property ($rose(s.pass) && s.algo == A_TOGGLE);
    c_fail_reset: cover property ($rose(s.fail) ##[1:30] $rose(s.done));
    c_abort: cover property (ctl_wr && reg_wdata_i[CTL_ABORT] && s.busy);

endmodule : flash_status_poller

// *** tb/flash_dev_model.sv ***
`timescale 1ns/100ps
module flash_dev_model import flash_poll_pkg::*; (
    // Flash pins
    input wire logic ce_b_i,
    input wire logic oe_b_i,
    input wire logic we_b_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DQ_W-1:0] wdq_i,
    output logic [DQ_W-1:0] dq_o,
    // Scenario control
    input wire logic start_i,
    input wire logic [2:0] mode_i,
    input wire logic [3:0] busy_i,
    input wire logic [DQ_W-1:0] array_i,
    output logic [DQ_W-1:0] last_wr_o
);
    // Modes: 0 read, 1 program, 2 erase, 3 stuck, 4 susp read, 5 susp prog
    logic [2:0] mode = '0;
    logic [3:0] left = '0;
    logic t1 = 1'b0;
    logic t2 = 1'b0;
    logic [DQ_W-1:0] word;
    logic [DQ_W-1:0] last = '0;

    // Load a scenario; busy_i counts status reads before completion
    initial last_wr_o = '0;
    always @(posedge start_i) begin
        mode = mode_i;
        left = busy_i;
        last_wr_o = '0;
    end

    // Status byte; bits with no status meaning keep array data
    always_comb begin
        word = array_i;
        if (mode inside {3'd1, 3'd3, 3'd5}) begin
            word[7:0] = {~array_i[7], t1, mode == 3'd3, array_i[4],
                1'b0, 1'b1, array_i[1:0]};
        end else if (mode == 3'd2) begin
            word[7:0] = {1'b0, t1, 1'b0, array_i[4], 1'b1, t2,
                array_i[1:0]};
        end else if (mode == 3'd4 && !addr_i[ADDR_W-1]) begin
            word[7:0] = {3'b110, array_i[4], 1'b0, t2, array_i[1:0]};
        end
    end // Other sectors and read mode give array data

    // Released bus shows the inverse of the last word, never a held value
    assign dq_o = (!ce_b_i && !oe_b_i) ? word : ~last;

    // A read ends when OE or CE rises while the other is still low
    always @(posedge oe_b_i or posedge ce_b_i) begin
        if (ce_b_i ^ oe_b_i) begin
            last = word;
            if (mode inside {3'd1, 3'd2, 3'd3, 3'd5}) begin
                t1 = ~t1;
            end
            if (mode == 3'd2 || (mode == 3'd4 && !addr_i[ADDR_W-1])) begin
                t2 = ~t2;
            end
            if (left == 4'd1 && mode != 3'd3) begin
                mode = 3'd0;
            end
            if (left != 4'd0) begin
                left = left - 4'd1;
            end
        end
    end

    // Last busy read: status gives way to array data mid-strobe, so the
    // host must accept either value on that read
    always @(negedge oe_b_i) begin
        if (!ce_b_i && left == 4'd1 && mode inside {3'd1, 3'd2, 3'd5}) begin
            #30 mode = 3'd0;
        end
    end

    // Host writes; the reset command is the only way out of a lock
    always @(posedge we_b_i) begin
        if (!ce_b_i) begin
            last_wr_o = wdq_i;
            if (wdq_i == RESET_CMD) begin
                mode = 3'd0;
            end
        end
    end
endmodule : flash_dev_model

// *** tb/flash_status_poller_bench.sv ***
`timescale 1ns/100ps
module flash_status_poller_bench import flash_poll_pkg::*;;
    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    logic clk_i, rst_b_i, reg_wr, reg_rd, ce_b, oe_b, we_b, dq_oe, start;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, st, r1, r2;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] dq_out, dev_dq, bus_dq, arr, last_wr, a, w;
    logic [2:0] mode, m;
    logic [3:0] busy;
    int err_total = 0;
    int n_checks = 0;

    // Data wire: whoever enables wins, the device otherwise
    assign bus_dq = dq_oe ? dq_out : dev_dq;

    flash_status_poller dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .ce_b_o(ce_b),
        .oe_b_o(oe_b), .we_b_o(we_b), .addr_o(addr), .dq_i(bus_dq),
        .dq_o(dq_out), .dq_oe_o(dq_oe));

    flash_dev_model dev (.ce_b_i(ce_b), .oe_b_i(oe_b), .we_b_i(we_b),
        .addr_i(addr), .wdq_i(dq_out), .dq_o(dev_dq), .start_i(start),
        .mode_i(mode), .busy_i(busy), .array_i(arr), .last_wr_o(last_wr));

    // 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic conclude;
        $display("mismatches %0d checks %0d", err_total, n_checks);
        if (err_total == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic write_reg(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_i);
        reg_wr <= 1'b0;
    endtask : write_reg

    // Read data stand only in the cycle after the strobe
    task automatic read_reg(input logic [7:0] ad, output logic [31:0] d);
        @(posedge clk_i);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge clk_i);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : read_reg

    // Bounded wait; a hang counts as a mismatch and ends the run
    task automatic wait_idle;
        int i;
        i = 0;
        st = 32'h0000_0001;
        while (st[STAT_BUSY] !== 1'b0 && i < 500) begin
            read_reg(REG_STATUS, st);
            i++;
        end
        if (st[STAT_BUSY] !== 1'b0) begin
            err_total++;
            conclude();
        end
    endtask : wait_idle

    task automatic load(input logic [2:0] md, input logic [3:0] b,
        input logic [DQ_W-1:0] ar);
        @(posedge clk_i);
        mode <= md;
        busy <= b;
        arr <= ar;
        start <= 1'b1;
        @(posedge clk_i);
        start <= 1'b0;
    endtask : load

    // One command: address, data, start bit, wait, fetch the last word
    task automatic run(input logic [31:0] ad, input logic [31:0] wd,
        input int bit_no);
        write_reg(REG_ADDR, ad);
        write_reg(REG_WDATA, wd);
        write_reg(REG_CTRL, 32'h1 << bit_no);
        wait_idle();
        read_reg(REG_RDATA, r1);
    endtask : run

    function automatic logic [31:0] exp_stat(input logic win,
        input logic ok);
        return {27'h0, win, ~ok, ok, 1'b1, 1'b0};
    endfunction : exp_stat

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_b_i = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        start = 1'b0;
        mode = '0;
        busy = '0;
        arr = '0;
        void'($urandom(32'hc2942e25));
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        // Reset values, write-only CTRL, unmapped place, ADDR width
        read_reg(REG_STATUS, st);
        chk(st, 32'h0);
        chk({28'h0, ce_b, oe_b, we_b, dq_oe}, 32'he);
        read_reg(REG_CTRL, st);
        chk(st, 32'h0);
        read_reg(8'h40, st);
        chk(st, 32'h0);
        write_reg(REG_ADDR, 32'hffff_ffff);
        read_reg(REG_ADDR, st);
        chk(st, 32'h0003_ffff);
        // Idle device: plain array data, then one single write
        a = 16'($urandom);
        load(3'd0, 4'd0, a);
        run(32'($urandom_range(0, 32'h0001_ffff)), '0, CTL_READ);
        chk(r1, {16'h0, a});
        w = {1'b1, 15'($urandom)};
        run('0, {16'h0, w}, CTL_WRITE);
        chk({16'h0, last_wr}, {16'h0, w});
        // Program, erase, suspended program; data poll and toggle poll
        for (int k = 0; k < 6; k++) begin
            m = (k < 2) ? 3'd1 : (k < 4) ? 3'd2 : 3'd5;
            a = (m == 3'd2) ? 16'hffff : 16'($urandom);
            load(m, 4'($urandom_range(1, 4)), a);
            run(32'h0000_0100, {16'h0, a}, k % 2);
            chk(st, exp_stat(a[3], 1'b1));
            chk(r1, {16'h0, a});
        end
        // Locked program: fail flag seen, host must send the reset
        for (int p = 0; p < 2; p++) begin
            a = 16'($urandom);
            load(3'd3, 4'd0, a);
            run(32'h0000_0100, {16'h0, a}, p);
            chk(st, exp_stat(1'b0, 1'b0));
            chk({16'h0, last_wr}, {16'h0, RESET_CMD});
        end
        // Suspended erase: other sector, suspended sector, suspend program
        a = 16'($urandom);
        load(3'd4, 4'd0, a);
        run(32'h0002_0000, '0, CTL_READ);
        chk(r1, {16'h0, a});
        run('0, '0, CTL_READ);
        r2 = r1;
        run('0, '0, CTL_READ);
        chk({30'h0, r1[7:6]}, 32'h3);
        chk({31'h0, r1[2] ^ r2[2]}, 32'h1);
        load(3'd5, 4'd3, a);
        run('0, '0, CTL_READ);
        chk({30'h0, r1[7], r1[2]}, {30'h0, ~a[7], 1'b1});
        // Abort a long toggle poll, then restart from the first read
        load(3'd1, 4'd15, a);
        write_reg(REG_CTRL, 32'h1 << CTL_TOGGLE_POLL);
        repeat (40) @(posedge clk_i);
        write_reg(REG_CTRL, 32'h1 << CTL_ABORT);
        wait_idle();
        run(32'h0000_0100, {16'h0, a}, CTL_TOGGLE_POLL);
        chk(st & 32'hf, 32'h6);
        chk(r1, {16'h0, a});
        conclude();
    end
endmodule : flash_status_poller_bench
